/* rtl/lams_line_alarm_mask_status.v */
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lams_defs.vh"

// Functional notes
// RULE1: system alarm indication mask, 0 enables, 1 masks, resets masked.
// RULE2: line alarm indication mask, 0 enables, 1 masks, resets masked.
// RULE3: test pattern sync change mask, 0 enables, resets masked.
// RULE4: error mask bit 5 masks system bipolar violation, resets 1.
// RULE5: error mask bit 4 masks line bipolar violation, resets 1.
// RULE6: error mask bit 3 masks system excess zeros, resets 1.
// RULE7: error mask bit 2 masks line excess zeros, resets 1.
// RULE8: error mask bit 1 masks pattern bit error, resets 1.
// RULE9: error mask bit 0 masks error count overflow; bits 7:6 reserved.
// RULE10: status bit 7 shows automatic loopback, zero after reset.
// RULE11: status bit 4 shows transmit over-current; bits 6:5 reserved.
// RULE12: status bit 3 shows transmit clock missing, zero after reset.
// RULE13: status bit 2 shows transmit loss of signal, zero after reset.
// RULE14: status bits 1/0 show system/line loss of signal.
// RULE15: interrupt output only when a latched event is set and unmasked.
// RULE16: latched event bits report on interrupt, cleared by writing one.
module lams_line_alarm_mask_status
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [`LAMS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`LAMS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // event pulses from the channel detectors
    input wire sys_ais_event,
    input wire line_ais_event,
    input wire pattern_sync_event,
    input wire sys_bpv_event,
    input wire line_bpv_event,
    input wire sys_exz_event,
    input wire line_exz_event,
    input wire pattern_error_event,
    input wire error_count_overflow_event,
    // condition levels from the channel detectors
    input wire auto_loopback_state,
    input wire tx_overcurrent_state,
    input wire tx_clock_missing_state,
    input wire tx_signal_loss_state,
    input wire sys_signal_loss_state,
    input wire line_signal_loss_state,
    // interrupt
    output reg irq
);

////////////////////////////////////////////////////////////////////////////
// register state

reg [7:0] mask1_q;
reg [7:0] mask2_q;
reg [7:0] stat_q;
reg [`LAMS_EV_W-1:0] istat_q;
reg [`LAMS_EV_W-1:0] istat_d;
reg [`LAMS_ADDR_W-1:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_held_q;
reg w_held_q;

wire [`LAMS_EV_W-1:0] events;
wire [`LAMS_EV_W-1:0] mask_vec;
wire [`LAMS_EV_W-1:0] wr_clear;
wire [`LAMS_EV_W-1:0] irq_src;
wire [7:0] stat_d;
wire irq_d;

// write path
wire do_write;
wire aw_take;
wire w_take;
wire aw_ready_d;
wire w_ready_d;
wire [`LAMS_ADDR_W-1:0] wr_addr;
wire [31:0] wr_data;
wire wr_lane0;
wire wr_hit_mask1;
wire wr_hit_mask2;
wire wr_hit_istat;
wire wr_hit_any;
reg [7:0] mask1_d;
reg [7:0] mask2_d;

// read path
wire ar_take;
reg [31:0] rd_word_d;
reg [1:0] rd_resp_d;

// event inputs in latch order
assign events[`LAMS_EV_SYS_AIS] = sys_ais_event;
assign events[`LAMS_EV_LINE_AIS] = line_ais_event;
assign events[`LAMS_EV_PSYNC] = pattern_sync_event;
assign events[`LAMS_EV_SYS_BPV] = sys_bpv_event;
assign events[`LAMS_EV_LINE_BPV] = line_bpv_event;
assign events[`LAMS_EV_SYS_EXZ] = sys_exz_event;
assign events[`LAMS_EV_LINE_EXZ] = line_exz_event;
assign events[`LAMS_EV_PAT_ERR] = pattern_error_event;
assign events[`LAMS_EV_CNT_OVF] = error_count_overflow_event;

// every latch sits beside the mask bit that gates it
assign mask_vec[`LAMS_EV_SYS_AIS] = mask1_q[`LAMS_M1_SYS_AIS];
assign mask_vec[`LAMS_EV_LINE_AIS] = mask1_q[`LAMS_M1_LINE_AIS];
assign mask_vec[`LAMS_EV_PSYNC] = mask1_q[`LAMS_M1_PSYNC];
assign mask_vec[`LAMS_EV_SYS_BPV] = mask2_q[`LAMS_M2_SYS_BPV];
assign mask_vec[`LAMS_EV_LINE_BPV] = mask2_q[`LAMS_M2_LINE_BPV];
assign mask_vec[`LAMS_EV_SYS_EXZ] = mask2_q[`LAMS_M2_SYS_EXZ];
assign mask_vec[`LAMS_EV_LINE_EXZ] = mask2_q[`LAMS_M2_LINE_EXZ];
assign mask_vec[`LAMS_EV_PAT_ERR] = mask2_q[`LAMS_M2_PAT_ERR];
assign mask_vec[`LAMS_EV_CNT_OVF] = mask2_q[`LAMS_M2_CNT_OVF];

////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order, held until both

// a beat counts only once its ready was seen with valid; acting on valid
// alone would commit a write the master still thinks is waiting
assign aw_take = s_axi_awvalid & s_axi_awready;
assign w_take = s_axi_wvalid & s_axi_wready;
assign do_write = (aw_held_q | aw_take) & (w_held_q | w_take)
                  & ~s_axi_bvalid;
assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
assign wr_lane0 = w_held_q ? wstrb_q[0] : s_axi_wstrb[0];
// ready drops while a beat is held or the response is still waiting
assign aw_ready_d = ~aw_held_q & ~s_axi_bvalid & ~do_write & ~aw_take;
assign w_ready_d = ~w_held_q & ~s_axi_bvalid & ~do_write & ~w_take;

assign wr_hit_mask1 = (wr_addr == `LAMS_ADDR_MASK1);
assign wr_hit_mask2 = (wr_addr == `LAMS_ADDR_MASK2);
assign wr_hit_istat = (wr_addr == `LAMS_ADDR_ISTAT);
assign wr_hit_any = wr_hit_mask1 | wr_hit_mask2 | wr_hit_istat;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awaddr_q <= {`LAMS_ADDR_W{1'b0}};
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `LAMS_RESP_OKAY;
    end
    else
    begin
        // ready is offered one cycle ahead so a held beat never blocks
        s_axi_awready <= aw_ready_d;
        s_axi_wready <= w_ready_d;
        if (aw_take && !do_write)
        begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        if (w_take && !do_write)
        begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // the status word is read-only: writing it is refused
            if (wr_hit_any)
                s_axi_bresp <= `LAMS_RESP_OKAY;
            else
                s_axi_bresp <= `LAMS_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// mask registers; reserved bits stay zero

always @*
begin
    mask1_d = mask1_q;
    mask2_d = mask2_q;
    // a write with the low byte lane off leaves the masks untouched
    if (do_write && wr_lane0)
    begin
        if (wr_hit_mask1)
            mask1_d = wr_data[7:0] & `LAMS_M1_USED; // RULE1 RULE2 RULE3
        if (wr_hit_mask2)
            mask2_d = wr_data[7:0] & `LAMS_M2_USED; // RULE4 RULE9
    end
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        mask1_q <= `LAMS_M1_RESET; // RULE1 RULE2 RULE3
        mask2_q <= `LAMS_M2_RESET; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9
    end
    else
    begin
        mask1_q <= mask1_d;
        mask2_q <= mask2_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// sticky event latches: a new event wins over a same-cycle clear

assign wr_clear = (do_write && wr_hit_istat)
                  ? wr_data[`LAMS_EV_W-1:0] : `LAMS_EV_RESET;

// the latch sets whatever the mask says, so masked events can be polled;
// irq follows the next latch value so it rises with the latch itself
// and a clear takes it down in the same cycle
assign irq_src = istat_d & ~mask_vec; // RULE15
assign irq_d = |irq_src; // RULE15

genvar gi;
generate
    for (gi = 0; gi < `LAMS_EV_W; gi = gi + 1)
    begin : g_ev
        always @*
        begin
            istat_d[gi] = events[gi] | (istat_q[gi] & ~wr_clear[gi]); // RULE16
        end
    end
endgenerate

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        istat_q <= `LAMS_EV_RESET;
        irq <= 1'b0;
    end
    else
    begin
        istat_q <= istat_d; // RULE16
        irq <= irq_d; // RULE15
    end
end

////////////////////////////////////////////////////////////////////////////
// condition status, sampled once a cycle

// levels are copied each cycle, not latched; a short blip can be missed
assign stat_d[`LAMS_ST_AUTO_LOOP] = auto_loopback_state; // RULE10
assign stat_d[`LAMS_ST_RSVD_HI:`LAMS_ST_RSVD_LO] = 2'b00; // RULE11
assign stat_d[`LAMS_ST_TX_OC] = tx_overcurrent_state; // RULE11
assign stat_d[`LAMS_ST_TX_CLK] = tx_clock_missing_state; // RULE12
assign stat_d[`LAMS_ST_TX_LOS] = tx_signal_loss_state; // RULE13
assign stat_d[`LAMS_ST_SYS_LOS] = sys_signal_loss_state; // RULE14
assign stat_d[`LAMS_ST_LINE_LOS] = line_signal_loss_state; // RULE14

always @(posedge aclk)
begin
    if (!aresetn)
        stat_q <= `LAMS_ST_RESET;
    else
        stat_q <= stat_d; // RULE10 RULE11 RULE12 RULE13 RULE14
end

////////////////////////////////////////////////////////////////////////////
// read channel: one read in flight, answer the cycle after the address

assign ar_take = s_axi_arvalid & s_axi_arready;

// unmapped words read as zero with an error response
always @*
begin
    rd_word_d = 32'h0000_0000;
    rd_resp_d = `LAMS_RESP_OKAY;
    case (s_axi_araddr)
        `LAMS_ADDR_MASK1: rd_word_d = {24'h000000, mask1_q};
        `LAMS_ADDR_MASK2: rd_word_d = {24'h000000, mask2_q};
        `LAMS_ADDR_STAT: rd_word_d = {24'h000000, stat_q};
        `LAMS_ADDR_ISTAT: rd_word_d = {23'h000000, istat_q};
        default:
        begin
            rd_word_d = 32'h0000_0000;
            rd_resp_d = `LAMS_RESP_SLVERR;
        end
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `LAMS_RESP_OKAY;
    end
    else
    begin
        // arready waits out the answer so only one read is ever open
        s_axi_arready <= ~s_axi_rvalid & ~ar_take;
        if (ar_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word_d;
            s_axi_rresp <= rd_resp_d;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

endmodule // lams_line_alarm_mask_status

/* rtl/lams_defs.vh */
`ifndef LAMS_DEFS_VH
`define LAMS_DEFS_VH
// byte addresses of the register words
`define LAMS_ADDR_MASK1 4'h0
`define LAMS_ADDR_MASK2 4'h4
`define LAMS_ADDR_STAT 4'h8
`define LAMS_ADDR_ISTAT 4'hc
`define LAMS_ADDR_IMASK 4'h0
`define LAMS_ADDR_W 4
// first mask register (alarm / pattern sync)
`define LAMS_M1_SYS_AIS 7
`define LAMS_M1_LINE_AIS 6
`define LAMS_M1_PSYNC 5
`define LAMS_M1_RESET 8'he0
`define LAMS_M1_USED 8'he0
// error_interrupt_mask fields
`define LAMS_M2_SYS_BPV 5
`define LAMS_M2_LINE_BPV 4
`define LAMS_M2_SYS_EXZ 3
`define LAMS_M2_LINE_EXZ 2
`define LAMS_M2_PAT_ERR 1
`define LAMS_M2_CNT_OVF 0
`define LAMS_M2_RESET 8'h3f
`define LAMS_M2_USED 8'h3f
// channel_condition_status fields
`define LAMS_ST_AUTO_LOOP 7
`define LAMS_ST_TX_OC 4
`define LAMS_ST_TX_CLK 3
`define LAMS_ST_TX_LOS 2
`define LAMS_ST_SYS_LOS 1
`define LAMS_ST_LINE_LOS 0
`define LAMS_ST_RESET 8'h00
`define LAMS_ST_RSVD_HI 6
`define LAMS_ST_RSVD_LO 5
// latched event positions; bits 5:0 match the error mask bits, bits 8:6 are gated by first mask bits 7:5
`define LAMS_EV_SYS_AIS 8
`define LAMS_EV_LINE_AIS 7
`define LAMS_EV_PSYNC 6
`define LAMS_EV_SYS_BPV 5
`define LAMS_EV_LINE_BPV 4
`define LAMS_EV_SYS_EXZ 3
`define LAMS_EV_LINE_EXZ 2
`define LAMS_EV_PAT_ERR 1
`define LAMS_EV_CNT_OVF 0
// interrupt event latch layout mirrors the two masks: {m1[7:5], m2[5:0]}
`define LAMS_EV_W 9
`define LAMS_EV_RESET 9'h000
`define LAMS_RESP_OKAY 2'b00
`define LAMS_RESP_SLVERR 2'b10
`endif

/* test/lams_line_alarm_mask_status_asserts.sv */
`timescale 1ns/1ps
module lams_checker
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // observed bus and interrupt
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire irq
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
// all masks come out of reset set, so early events cannot raise irq
start_quiet_a: assert property ($rose(aresetn) |-> (!irq)[*3])
    else $error("irq high right after reset");
reset_idle_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid)
    else $error("outputs not idle after reset");
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
    else $error("upper read bits set");
write_single_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("second write accepted");
read_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
endmodule // lams_checker

bind lams_line_alarm_mask_status lams_checker u_chk (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

/* test/lams_line_alarm_mask_status_tb.sv */
`timescale 1ns/1ps
module lams_line_alarm_mask_status_tb;
logic aclk, aresetn, awv, wv, bvalid, bready, arv, rvalid, rready, irq;
logic awr, wr_rdy, arr;
logic [3:0] awa, ara;
logic [31:0] wd, rdata, d;
logic [1:0] bresp, rresp, r;
logic [8:0] ev;
logic [5:0] st;
logic [38:0] rows [0:8];
int n_mismatch, checks_done, cyc, i;
lams_line_alarm_mask_status u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sys_ais_event(ev[8]), .line_ais_event(ev[7]),
    .pattern_sync_event(ev[6]), .sys_bpv_event(ev[5]),
    .line_bpv_event(ev[4]), .sys_exz_event(ev[3]), .line_exz_event(ev[2]),
    .pattern_error_event(ev[1]), .error_count_overflow_event(ev[0]),
    .auto_loopback_state(st[5]), .tx_overcurrent_state(st[4]),
    .tx_clock_missing_state(st[3]), .tx_signal_loss_state(st[2]),
    .sys_signal_loss_state(st[1]), .line_signal_loss_state(st[0]),
    .irq(irq));
////////////////////////////////////////////////////////////////////////
task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
        n_mismatch++;
        $display("BAD %0t got %h want %h", $time, got, exp);
    end
endtask
// each beat is released at the edge that takes it; the answer's ready is
// raised only once valid is seen, so the slave must hold its answer
task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] q);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (aw_p || w_p)
    begin
        @(posedge aclk);
        if (aw_p && awr)
        begin
            awv <= 1'b0;
            aw_p = 1'b0;
        end
        if (w_p && wr_rdy)
        begin
            wv <= 1'b0;
            w_p = 1'b0;
        end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    q = bresp;
    bready <= 1'b0;
endtask
task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    q = rresp;
    rready <= 1'b0;
endtask
task row(input int k);
    if (rows[k][38]) wr(rows[k][37:34], rows[k][33:2], r);
    else rd(rows[k][37:34], d, r);
    chk({30'h0, r}, {30'h0, rows[k][1:0]});
    if (!rows[k][38]) chk(d, rows[k][33:2]);
endtask
task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task irq_is(input logic v);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, v});
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
    aclk = 0;
    forever #5 aclk = ~aclk;
end
always @(posedge aclk)
begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
        n_mismatch++;
        report_and_stop();
    end
end
initial
begin
    {aresetn, awv, wv, bready, arv, rready, awa, ara, wd, ev, st} = '0;
    {n_mismatch, checks_done, cyc} = '0;
    rows = '{{5'h00, 32'he0, 2'h0}, {5'h04, 32'h3f, 2'h0},
        {5'h08, 32'h0, 2'h0}, {5'h0c, 32'h0, 2'h0}, {5'h10, 32'hff, 2'h0},
        {5'h00, 32'he0, 2'h0}, {5'h14, 32'h2a, 2'h0},
        {5'h04, 32'h2a, 2'h0}, {5'h18, 32'h0, 2'h2}};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 9; i++) row(i);
    for (i = 0; i < 2; i++)
    begin
        @(posedge aclk) st <= i ? 6'h15 : 6'h2a;
        rd(4'h8, d, r);
        chk(d, i ? 32'h15 : 32'h8a);
    end
    wr(4'h4, 32'h3f, r);
    @(posedge aclk) ev <= 9'h1ff;
    @(posedge aclk) ev <= 9'h0;
    irq_is(1'b0);
    rd(4'hc, d, r);
    chk(d, 32'h1ff);
    wr(4'h4, 32'h3e, r);
    irq_is(1'b1);
    wr(4'hc, 32'h001, r);
    irq_is(1'b0);
    wr(4'h0, 32'h60, r);
    irq_is(1'b1);
    wr(4'hc, 32'h100, r);
    irq_is(1'b0);
    rd(4'hc, d, r);
    chk(d, 32'h0fe);
    @(posedge aclk) aresetn <= 1'b0;
    st <= '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i++) row(i);
    report_and_stop();
end
endmodule // lams_line_alarm_mask_status_tb
